// File: rtl/can_msgobj_enable_status.sv
// Message object busy tracking with read-only enable status registers
//
// Chosen here: the Wishbone slave port.
module can_msgobj_enable_status (
  input wire logic clk_i,
  input wire logic rst_i,
  input can_busy_pkg::wb_req_t wb_req_i,
  input can_busy_pkg::obj_evt_t obj_evt_i,
  output can_busy_pkg::wb_rsp_t wb_rsp_o,
  output logic [can_busy_pkg::NUM_OBJ-1:0] busy_o,
  output logic [can_busy_pkg::PAGE_W-1:0] page_o,
  output logic irq_o
);

  typedef struct packed {
    logic [can_busy_pkg::PAGE_W-1:0] page;
    logic [can_busy_pkg::NUM_OBJ-1:0][1:0] mode;
    logic [can_busy_pkg::IRQ_W-1:0] irq_status;
    logic [can_busy_pkg::IRQ_W-1:0] irq_enable;
    logic irq;
  } top_state_t;

  top_state_t state_r;
  top_state_t state_nxt;

  logic wr;
  logic [can_busy_pkg::DAT_W-1:0] rdata;
  logic [can_busy_pkg::NUM_OBJ-1:0] busy;
  logic [can_busy_pkg::NUM_OBJ-1:0] obj_set;
  logic [can_busy_pkg::NUM_OBJ-1:0] obj_clr;
  logic [can_busy_pkg::NUM_OBJ-1:0] obj_done;
  logic [can_busy_pkg::NUM_OBJ-1:0] obj_sel;
  logic [1:0] new_mode;
  logic ctrl_wr;
  logic page_valid;
  logic flush;
  logic [can_busy_pkg::IRQ_W-1:0] irq_evt;

  wb_sfr_port u_port (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .req_i(wb_req_i),
    .rdata_i(rdata),
    .rsp_o(wb_rsp_o),
    .wr_o(wr)
  );

  assign page_valid = state_r.page < can_busy_pkg::PAGE_W'(can_busy_pkg::NUM_OBJ);
  assign ctrl_wr = wr & (wb_req_i.adr == can_busy_pkg::ADDR_CTRL) & page_valid;
  assign new_mode = wb_req_i.dat[can_busy_pkg::CTRL_MODE_LSB +: 2];
  assign flush = obj_evt_i.abort | obj_evt_i.standby;

  genvar g;
  generate
    for (g = 0; g < can_busy_pkg::NUM_OBJ; g++) begin : g_obj
      assign obj_sel[g] = ctrl_wr & (state_r.page == can_busy_pkg::PAGE_W'(g));
      // Auto-reply objects complete only on their reply transmission
      assign obj_done[g] = (state_r.mode[g] == can_busy_pkg::MODE_AUTO_REPLY) ?
        obj_evt_i.tx_done[g] : (obj_evt_i.tx_done[g] | obj_evt_i.rx_done[g]);
      // Enabling mode written: object becomes in use
      assign obj_set[g] = obj_sel[g] & (new_mode != can_busy_pkg::MODE_DISABLED);
      // Disable, done, abort and standby free the object; an enabling rewrite keeps it in use
      assign obj_clr[g] = obj_sel[g] | obj_done[g] | flush;

      msgobj_busy_bit u_bit (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .set_i(obj_set[g]),
        .clr_i(obj_clr[g]),
        .busy_o(busy[g])
      );
    end
  endgenerate

  // One means in use, zero means free
  assign busy_o = busy;

  assign irq_evt[can_busy_pkg::IRQ_DONE_BIT] = |(busy & obj_done);
  assign irq_evt[can_busy_pkg::IRQ_FLUSH_BIT] = flush & (|busy);

  always_comb begin
    rdata = can_busy_pkg::DATA_ZERO;
    unique case (wb_req_i.adr)
      can_busy_pkg::ADDR_BUSY_HIGH: begin
        // Reserved top bit reads zero
        rdata = {1'b0, busy[can_busy_pkg::NUM_OBJ-1:can_busy_pkg::LOW_OBJS]};
      end
      can_busy_pkg::ADDR_BUSY_LOW: begin
        rdata = busy[can_busy_pkg::LOW_OBJS-1:0];
      end
      can_busy_pkg::ADDR_PAGE: begin
        rdata = {4'h0, state_r.page};
      end
      can_busy_pkg::ADDR_CTRL: begin
        if (page_valid) begin
          rdata = {state_r.mode[state_r.page], 6'h00};
        end
      end
      can_busy_pkg::ADDR_IRQ_STATUS: begin
        rdata = {6'h00, state_r.irq_status};
      end
      can_busy_pkg::ADDR_IRQ_ENABLE: begin
        rdata = {6'h00, state_r.irq_enable};
      end
      default: begin
        rdata = can_busy_pkg::DATA_ZERO;
      end
    endcase
  end

  always_comb begin
    state_nxt = state_r;
    if (wr) begin
      // Busy registers have no write path at all
      unique case (wb_req_i.adr)
        can_busy_pkg::ADDR_PAGE: begin
          state_nxt.page = wb_req_i.dat[can_busy_pkg::PAGE_W-1:0];
        end
        can_busy_pkg::ADDR_IRQ_ENABLE: begin
          state_nxt.irq_enable = wb_req_i.dat[can_busy_pkg::IRQ_W-1:0];
        end
        can_busy_pkg::ADDR_IRQ_CLEAR: begin
          state_nxt.irq_status = state_r.irq_status & ~wb_req_i.dat[can_busy_pkg::IRQ_W-1:0];
        end
        default: begin
          state_nxt.page = state_r.page;
        end
      endcase
    end
    if (ctrl_wr) begin
      state_nxt.mode[state_r.page] = new_mode;
    end
    // New events win over a clear in the same cycle
    state_nxt.irq_status = state_nxt.irq_status | irq_evt;
    state_nxt.irq = |(state_nxt.irq_status & state_nxt.irq_enable);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r.page <= can_busy_pkg::PAGE_RST;
      state_r.mode <= '0;
      state_r.irq_status <= can_busy_pkg::IRQ_RST;
      state_r.irq_enable <= can_busy_pkg::IRQ_RST;
      state_r.irq <= 1'b0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign page_o = state_r.page;
  assign irq_o = state_r.irq;

endmodule

// File: rtl/can_busy_pkg.sv
// Shared constants, register map and carrier types for the message object busy block
package can_busy_pkg;

  localparam int NUM_OBJ = 15;
  localparam int LOW_OBJS = 8;
  localparam int HIGH_OBJS = 7;
  localparam int ADR_W = 8;
  localparam int DAT_W = 8;
  localparam int PAGE_W = 4;
  localparam int IRQ_W = 2;

  // Register byte addresses
  localparam logic [ADR_W-1:0] ADDR_BUSY_HIGH = 8'hce;
  localparam logic [ADR_W-1:0] ADDR_BUSY_LOW = 8'hcf;
  localparam logic [ADR_W-1:0] ADDR_PAGE = 8'hd0;
  localparam logic [ADR_W-1:0] ADDR_CTRL = 8'hd1;
  localparam logic [ADR_W-1:0] ADDR_IRQ_STATUS = 8'hd2;
  localparam logic [ADR_W-1:0] ADDR_IRQ_ENABLE = 8'hd3;
  localparam logic [ADR_W-1:0] ADDR_IRQ_CLEAR = 8'hd4;

  // Field positions
  localparam int CTRL_MODE_LSB = 6;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_FLUSH_BIT = 1;

  // Reset values
  localparam logic [DAT_W-1:0] DATA_ZERO = 8'h00;
  localparam logic [PAGE_W-1:0] PAGE_RST = 4'h0;
  localparam logic [IRQ_W-1:0] IRQ_RST = 2'h0;
  localparam logic [NUM_OBJ-1:0] OBJ_NONE = 15'h0000;

  typedef enum logic [1:0] {
    MODE_DISABLED = 2'h0,
    MODE_TX = 2'h1,
    MODE_RX = 2'h2,
    MODE_AUTO_REPLY = 2'h3
  } obj_mode_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic sel;
    logic [ADR_W-1:0] adr;
    logic [DAT_W-1:0] dat;
  } wb_req_t;

  typedef struct packed {
    logic ack;
    logic [DAT_W-1:0] dat;
  } wb_rsp_t;

  // Completion events from the protocol side, one bit per object, plus shared abort and standby flush bits
  typedef struct packed {
    logic [NUM_OBJ-1:0] rx_done;
    logic [NUM_OBJ-1:0] tx_done;
    logic abort;
    logic standby;
  } obj_evt_t;

endpackage

// File: rtl/msgobj_busy_bit.sv
// One message object busy flag with set-over-clear priority
module msgobj_busy_bit (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic set_i,
  input wire logic clr_i,
  output logic busy_o
);

  typedef struct packed {
    logic busy;
  } busy_state_t;

  busy_state_t state_r;
  busy_state_t state_nxt;

  always_comb begin
    state_nxt = state_r;
    // Enable seen in the same cycle as a clear must not be lost
    state_nxt.busy = set_i | (state_r.busy & ~clr_i);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign busy_o = state_r.busy;

endmodule

// File: rtl/wb_sfr_port.sv
// Classic Wishbone slave front end: one wait state, registered read data
module wb_sfr_port (
  input wire logic clk_i,
  input wire logic rst_i,
  input can_busy_pkg::wb_req_t req_i,
  input wire logic [can_busy_pkg::DAT_W-1:0] rdata_i,
  output can_busy_pkg::wb_rsp_t rsp_o,
  output logic wr_o
);

  typedef struct packed {
    logic ack;
    logic [can_busy_pkg::DAT_W-1:0] dat;
  } port_state_t;

  port_state_t state_r;
  port_state_t state_nxt;
  logic active;

  assign active = req_i.cyc & req_i.stb;

  always_comb begin
    state_nxt = state_r;
    // Ack one cycle after the request, drop it the cycle after
    state_nxt.ack = active & ~state_r.ack;
    state_nxt.dat = (active & ~state_r.ack & ~req_i.we) ? rdata_i : can_busy_pkg::DATA_ZERO;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Write lands on the edge where the master sees ack
  assign wr_o = active & req_i.we & req_i.sel & state_r.ack;
  assign rsp_o.ack = state_r.ack;
  assign rsp_o.dat = state_r.dat;

endmodule

// File: dv/can_busy_props.sv
// Port level assertions for the message object busy block
module can_busy_props (
  input wire logic clk_i,
  input wire logic rst_i,
  input can_busy_pkg::wb_req_t wb_req_i,
  input can_busy_pkg::obj_evt_t obj_evt_i,
  input can_busy_pkg::wb_rsp_t wb_rsp_o,
  input wire logic [can_busy_pkg::NUM_OBJ-1:0] busy_o,
  input wire logic [can_busy_pkg::PAGE_W-1:0] page_o,
  input wire logic irq_o
);
  logic req, rd, wr_ctl, wr_ro;
  assign req = wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack;
  assign rd = req && !wb_req_i.we;
  // Control write lands at the ack edge
  assign wr_ctl = wb_req_i.cyc && wb_rsp_o.ack && wb_req_i.we && wb_req_i.sel
    && wb_req_i.adr == can_busy_pkg::ADDR_CTRL;
  assign wr_ro = wb_req_i.cyc && wb_rsp_o.ack && wb_req_i.we
    && (wb_req_i.adr == can_busy_pkg::ADDR_BUSY_HIGH || wb_req_i.adr == can_busy_pkg::ADDR_BUSY_LOW);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_follows: assert property (req |=> wb_rsp_o.ack) else $error("ack late");
  a_ack_pulse: assert property (wb_rsp_o.ack |=> !wb_rsp_o.ack) else $error("ack long");
  a_dat_idle: assert property (!wb_rsp_o.ack |-> wb_rsp_o.dat == 8'h00) else $error("dat");
  a_read_high: assert property (rd && wb_req_i.adr == can_busy_pkg::ADDR_BUSY_HIGH
    |=> wb_rsp_o.dat == {1'b0, $past(busy_o[14:8])}) else $error("high byte");
  a_read_low: assert property (rd && wb_req_i.adr == can_busy_pkg::ADDR_BUSY_LOW
    |=> wb_rsp_o.dat == $past(busy_o[7:0])) else $error("low byte");
  a_busy_rise: assert property (!wr_ctl |=> (busy_o & ~$past(busy_o)) == '0)
    else $error("busy set without enable");
  a_done_clear: assert property (!wr_ctl |=> (busy_o & $past(obj_evt_i.tx_done)) == '0)
    else $error("busy kept after done");
  a_flush_clear: assert property ((obj_evt_i.abort || obj_evt_i.standby) && !wr_ctl
    |=> busy_o == '0) else $error("busy kept after flush");
  a_ro_ignore: assert property (wr_ro && obj_evt_i == '0 |=> $stable(busy_o))
    else $error("status write took effect");
  a_page_write: assert property (wb_rsp_o.ack && wb_req_i.we && wb_req_i.sel
    && wb_req_i.cyc && wb_req_i.adr == can_busy_pkg::ADDR_PAGE
    |=> page_o == $past(wb_req_i.dat[3:0])) else $error("page not taken");
  a_irq_masked: assert property (wb_rsp_o.ack && wb_req_i.we && wb_req_i.sel
    && wb_req_i.cyc && wb_req_i.adr == can_busy_pkg::ADDR_IRQ_ENABLE
    && wb_req_i.dat == 8'h00 |=> !irq_o) else $error("irq while masked");
endmodule

bind can_msgobj_enable_status can_busy_props chk (.clk_i(clk_i), .rst_i(rst_i),
  .wb_req_i(wb_req_i), .obj_evt_i(obj_evt_i), .wb_rsp_o(wb_rsp_o), .busy_o(busy_o),
  .page_o(page_o), .irq_o(irq_o));

// File: dv/can_node_model.sv
// Protocol side stand-in that raises completion and flush events
module can_node_model (
  input wire logic clk_i,
  output can_busy_pkg::obj_evt_t evt_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial evt_o = '0;
  // One-cycle pulse launched just after an edge
  task automatic pulse(input can_busy_pkg::obj_evt_t e);
    @(posedge clk_i);
    evt_o <= e;
    @(posedge clk_i);
    evt_o <= '0;
  endtask
endmodule

// File: dv/can_msgobj_enable_status_tb.sv
// Register level bench for the message object busy block
module can_msgobj_enable_status_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] HI = can_busy_pkg::ADDR_BUSY_HIGH;
  localparam logic [7:0] LO = can_busy_pkg::ADDR_BUSY_LOW;
  localparam logic [7:0] PG = can_busy_pkg::ADDR_PAGE;
  localparam logic [7:0] ST = can_busy_pkg::ADDR_IRQ_STATUS;
  logic clk_i = 1'b0;
  logic rst_i;
  logic irq;
  logic [7:0] got;
  can_busy_pkg::wb_req_t req;
  can_busy_pkg::wb_rsp_t rsp;
  can_busy_pkg::obj_evt_t evt;
  int n_fail;
  int n_compared;
  always #5 clk_i = ~clk_i;
  can_node_model node (.clk_i(clk_i), .evt_o(evt));
  can_msgobj_enable_status uut (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req),
    .obj_evt_i(evt), .wb_rsp_o(rsp), .busy_o(), .page_o(), .irq_o(irq));
  task report_and_stop;
    if (n_fail == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task cmp(input string nm, input logic [7:0] e, input logic [7:0] v);
    n_compared++;
    if (v !== e) begin
      $display("MISMATCH %s expected %h seen %h", nm, e, v);
      n_fail++;
    end
  endtask
  // Waits for ack, takes data at that edge, then leaves one idle cycle
  task wt;
    int i;
    i = 0;
    do begin
      @(posedge clk_i);
      i++;
    end while (rsp.ack !== 1'b1 && i < 20);
    got = rsp.dat;
    req <= '0;
    if (rsp.ack !== 1'b1) begin
      cmp("ack", 8'h01, 8'h00);
      report_and_stop;
    end
    @(posedge clk_i);
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    req <= '{1'b1, 1'b1, 1'b1, 1'b1, a, d};
    wt;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    req <= '{1'b1, 1'b1, 1'b0, 1'b1, a, 8'h00};
    wt;
    cmp("rdata", e, got);
  endtask
  task en(input logic [7:0] o, input logic [1:0] m);
    wr(PG, o);
    wr(can_busy_pkg::ADDR_CTRL, {m, 6'h00});
  endtask
  // Kind 0 receive, 1 transmit, 2 abort, 3 standby
  task ev(input int k, input int i);
    can_busy_pkg::obj_evt_t e;
    e = '0;
    if (k == 0) e.rx_done[i] = 1'b1;
    if (k == 1) e.tx_done[i] = 1'b1;
    e.abort = (k == 2);
    e.standby = (k == 3);
    node.pulse(e);
  endtask
  initial begin
    rst_i = 1'b1;
    req = '0;
    n_fail = 0;
    n_compared = 0;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(HI, 8'h00);
    rd(LO, 8'h00);
    en(8'd3, 2'd1);
    en(8'd12, 2'd2);
    en(8'd5, 2'd3);
    rd(LO, 8'h28);
    rd(HI, 8'h10);
    wr(LO, 8'hff);
    wr(HI, 8'h7f);
    rd(LO, 8'h28);
    rd(HI, 8'h10);
    wr(can_busy_pkg::ADDR_IRQ_ENABLE, 8'h01);
    ev(1, 3);
    rd(LO, 8'h20);
    cmp("irq", 8'h01, {7'h00, irq});
    rd(PG, 8'h05);
    rd(ST, 8'h01);
    wr(can_busy_pkg::ADDR_IRQ_CLEAR, 8'h01);
    rd(ST, 8'h00);
    cmp("irq", 8'h00, {7'h00, irq});
    ev(0, 5);
    rd(LO, 8'h20);
    ev(1, 5);
    rd(LO, 8'h00);
    wr(can_busy_pkg::ADDR_IRQ_CLEAR, 8'h03);
    wr(can_busy_pkg::ADDR_IRQ_ENABLE, 8'h00);
    en(8'd4, 2'd1);
    ev(1, 4);
    rd(ST, 8'h01);
    cmp("irq", 8'h00, {7'h00, irq});
    en(8'd12, 2'd1);
    rd(HI, 8'h10);
    en(8'd12, 2'd0);
    rd(HI, 8'h00);
    en(8'h09, 2'h2);
    rd(HI, 8'h02);
    ev(0, 9);
    rd(HI, 8'h00);
    en(8'd0, 2'd1);
    ev(2, 0);
    rd(LO, 8'h00);
    rd(ST, 8'h03);
    en(8'd14, 2'd2);
    rd(can_busy_pkg::ADDR_CTRL, 8'h80);
    ev(3, 0);
    rd(HI, 8'h00);
    rd(8'h55, 8'h00);
    report_and_stop;
  end
endmodule
